// ### design/upc_pkg.sv
// Shared constants, types and helpers for the upconverter channel back end
package upc_pkg;
    localparam logic [6:0] ADDR_LEAP_HI = 7'h02;
    localparam logic [6:0] ADDR_LEAP_LO = 7'h03;
    localparam logic [6:0] ADDR_PHASE = 7'h07;
    localparam logic [6:0] ADDR_FREQ_HI = 7'h08;
    localparam logic [6:0] ADDR_FREQ_LO = 7'h09;
    localparam logic [6:0] ADDR_MAIN = 7'h0c;
    localparam logic [6:0] ADDR_FIR = 7'h0d;
    localparam logic [6:0] ADDR_DEV = 7'h78;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int HB_EN_BIT = 9;
    localparam int MAIN_MODE_BIT = 7;
    localparam int DEV_MODE_LSB = 8;
    localparam int DEV_POS_LSB = 1;
    localparam int DEV_CASC_EN_BIT = 3;
    localparam int DEV_STRB_EN_BIT = 5;
    localparam logic signed [47:0] HB_C0 = 48'sh3;
    localparam logic signed [47:0] HB_C1 = -48'sh19;
    localparam logic signed [47:0] HB_C2 = 48'sh96;
    localparam int HB_SHIFT = 8;
    localparam int FRAC_SHIFT = 8;
    localparam int MIX_SHIFT = 18;
    localparam int PHASE_MSB = 31;
    localparam int PHASE_BITS = 6;
    localparam logic signed [18:0] SIN_ONE = 19'sh3ffff;
    localparam logic signed [20:0] S21_MAX = 21'sh0fffff;
    localparam logic signed [20:0] S21_MIN = -21'sh100000;

    typedef enum logic [2:0] {
        M_CASCADE = 3'b000,
        M_REAL = 3'b001,
        M_IMAG = 3'b010,
        M_MUXED = 3'b011,
        M_MUXED_2X = 3'b100,
        M_CPLX1 = 3'b101,
        M_CPLX2 = 3'b110,
        M_CPLX3 = 3'b111
    } out_mode_t;

    typedef struct packed {
        logic signed [20:0] re;
        logic signed [20:0] im;
    } cplx_t;

    typedef struct packed {
        logic ce_n;
        logic wr_n;
        logic rd_n;
        logic [6:0] addr;
        logic [15:0] data;
    } cpu_pins_t;

    typedef struct packed {
        logic [19:0] re;
        logic [19:0] im;
    } bus_pair_t;

    // Clamp to the 21-bit signed range instead of wrapping
    function automatic logic signed [20:0] sat21(input logic signed [47:0] v);
        if (v > 48'(S21_MAX)) begin
            return S21_MAX;
        end else if (v < 48'(S21_MIN)) begin
            return S21_MIN;
        end
        return v[20:0];
    endfunction : sat21
endpackage : upc_pkg

// ### design/carrier_nco.sv
// Carrier phase accumulator with preset and sine/cosine lookup
`timescale 1ns/1ps
`default_nettype none
module carrier_nco (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] carrier_increment,
    input wire logic [15:0] carrier_phase_word,
    input wire logic preset,
    output logic signed [18:0] sin_out,
    output logic signed [18:0] cos_out,
    output logic freq_zero
);
    import upc_pkg::*;

    typedef struct packed {
        logic [31:0] acc;
        logic signed [18:0] sin_v;
        logic signed [18:0] cos_v;
        logic zero;
    } nco_state_t;

    nco_state_t st;
    nco_state_t next_st;

    // One quadrant, 16 steps; the other three are mirrored
    function automatic logic signed [18:0] quarter(input logic [3:0] k);
        case (k)
            4'h0: return 19'sh00000;
            4'h1: return 19'sh0645e;
            4'h2: return 19'sh0c7c6;
            4'h3: return 19'sh12940;
            4'h4: return 19'sh187de;
            4'h5: return 19'sh1e2b5;
            4'h6: return 19'sh238e7;
            4'h7: return 19'sh2899e;
            4'h8: return 19'sh2d413;
            4'h9: return 19'sh3178f;
            4'ha: return 19'sh3536c;
            4'hb: return 19'sh38715;
            4'hc: return 19'sh3b20d;
            4'hd: return 19'sh3d3e8;
            4'he: return 19'sh3ec52;
            default: return 19'sh3fb11;
        endcase
    endfunction : quarter

    function automatic logic signed [18:0] qsin(input logic [5:0] p);
        logic [4:0] idx;
        logic signed [18:0] mag;
        idx = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
        mag = idx[4] ? SIN_ONE : quarter(idx[3:0]);
        return p[5] ? -mag : mag;
    endfunction : qsin

    always_comb begin
        next_st = st;
        next_st.zero = (carrier_increment == 32'h00000000);
        if (preset) begin
            next_st.acc = {carrier_phase_word, 16'h0000};
        end else begin
            next_st.acc = st.acc + carrier_increment;
        end
        // Counterclockwise for a rising phase, clockwise for a falling one
        next_st.sin_v = qsin(st.acc[PHASE_MSB -: PHASE_BITS]);
        next_st.cos_v = qsin(6'(st.acc[PHASE_MSB -: PHASE_BITS] + 6'h10));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sin_out = st.sin_v;
    assign cos_out = st.cos_v;
    assign freq_zero = st.zero;

    chk_preset_load: assert property (@(posedge clk) disable iff (rst)
        preset |=> st.acc == {$past(carrier_phase_word), 16'h0000})
        else $error("phase offset not loaded into accumulator");
    chk_acc_step: assert property (@(posedge clk) disable iff (rst)
        !preset |=> st.acc == 32'($past(st.acc) + $past(carrier_increment)))
        else $error("accumulator did not step by increment");
endmodule : carrier_nco
`default_nettype wire

// ### design/upconverter_channel_backend.sv
// Channel back end: half-band, interpolator, carrier mixer and output stage
`timescale 1ns/1ps
`default_nettype none
module upconverter_channel_backend (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic CPU_CE_N,
    input wire logic CPU_WR_N,
    input wire logic CPU_RD_N,
    input wire logic [6:0] CPU_ADDR,
    input wire logic [15:0] CPU_DATA_IN,
    output logic [15:0] CPU_DATA_OUT,
    output logic CPU_DATA_OE,
    input wire upc_pkg::cplx_t SHAPED_IQ,
    input wire logic SHAPED_VALID,
    input wire logic [7:0] FINE_PHASE,
    input wire upc_pkg::cplx_t [2:0] OTHER_CHANNELS,
    input wire logic CARRIER_SYNC,
    input wire logic [19:0] CASC_REAL_IN,
    input wire logic [19:0] CASC_IMAG_IN,
    output logic [19:0] CASC_REAL_OUT,
    output logic [19:0] CASC_IMAG_OUT,
    output logic CASC_OE,
    output logic [19:0] OUT_REAL_BUS,
    output logic [19:0] OUT_IMAG_BUS,
    output logic REAL_SAMPLE_STROBE,
    output logic [31:0] LEAP_COUNT_VALUE
);
    import upc_pkg::*;

    typedef struct packed {
        cpu_pins_t c1;
        cpu_pins_t c2;
        logic wr_last;
        logic ce_last;
        logic sync1;
        logic sync2;
        logic sync_last;
        logic [15:0] leap_hi;
        logic [15:0] leap_lo;
        logic [15:0] phase_off;
        logic [15:0] freq_hi;
        logic [15:0] freq_lo;
        logic [15:0] main_ctl;
        logic [15:0] fir_ctl;
        logic [15:0] dev_ctl;
        logic preset;
        logic [15:0] rd_data;
        logic rd_oe;
        cplx_t [5:0] hb_line;
        logic hb_pend;
        cplx_t hb_cur;
        cplx_t hb_prev;
        cplx_t interp;
        cplx_t mix;
        cplx_t sum;
        cplx_t [3:0] sum_d;
        bus_pair_t p1;
        bus_pair_t p2;
        cplx_t casc_in;
        cplx_t chain;
        logic mux_phase;
        logic signed [20:0] mux_hold;
        logic strobe;
        logic [3:0][19:0] bus_hi;
        logic [3:0][19:0] bus_lo;
        logic oe;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic signed [18:0] nco_sin;
    logic signed [18:0] nco_cos;
    logic nco_zero;
    out_mode_t mode;
    logic [1:0] chain_pos;

    // Bus slots: 0 cascade real, 1 cascade imag, 2 out real, 3 out imag
    localparam int B_CR = 0;
    localparam int B_CI = 1;
    localparam int B_OR = 2;
    localparam int B_OI = 3;

    function automatic logic signed [20:0] hb_a(input logic signed [20:0] a0,
            input logic signed [20:0] a1, input logic signed [20:0] a2,
            input logic signed [20:0] a3, input logic signed [20:0] a4,
            input logic signed [20:0] a5);
        logic signed [47:0] acc;
        acc = HB_C0 * (48'(a0) + 48'(a5)) + HB_C1 * (48'(a1) + 48'(a4))
            + HB_C2 * (48'(a2) + 48'(a3));
        // Round half up before dropping the coefficient scale
        acc = acc + 48'sh80;
        return sat21(acc >>> HB_SHIFT);
    endfunction : hb_a

    function automatic logic signed [20:0] lerp(input logic signed [20:0] p,
            input logic signed [20:0] c, input logic [7:0] f);
        logic signed [47:0] d;
        d = (48'(c) - 48'(p)) * 48'($signed({1'b0, f}));
        return sat21(48'(p) + (d >>> FRAC_SHIFT));
    endfunction : lerp

    function automatic logic signed [20:0] mixp(input logic signed [20:0] a,
            input logic signed [18:0] b, input logic signed [20:0] c,
            input logic signed [18:0] d, input logic sub);
        logic signed [47:0] x;
        logic signed [47:0] y;
        x = 48'(a) * 48'(b);
        y = 48'(c) * 48'(d);
        return sat21((sub ? x - y : x + y) >>> MIX_SHIFT);
    endfunction : mixp

    carrier_nco u_nco (
        .clk(REF_CLK),
        .rst(RESET),
        .carrier_increment({st.freq_hi, st.freq_lo}),
        .carrier_phase_word(st.phase_off),
        .preset(st.preset),
        .sin_out(nco_sin),
        .cos_out(nco_cos),
        .freq_zero(nco_zero)
    );

    assign mode = out_mode_t'({st.main_ctl[MAIN_MODE_BIT],
        st.dev_ctl[DEV_MODE_LSB +: 2]});
    assign chain_pos = st.dev_ctl[DEV_POS_LSB +: 2];

    always_comb begin
        logic commit;
        logic hb_en;
        cplx_t nline0;
        cplx_t src;
        cplx_t dly;
        logic [19:0] re20;
        logic [19:0] im20;
        logic [19:0] mx;
        commit = 1'b0;
        hb_en = 1'b0;
        nline0 = '0;
        src = '0;
        dly = '0;
        re20 = '0;
        im20 = '0;
        mx = '0;
        next_st = st;

        // Pins pass two stages before use; stage one feeds stage two only
        next_st.c1 = {CPU_CE_N, CPU_WR_N, CPU_RD_N, CPU_ADDR, CPU_DATA_IN};
        next_st.c2 = st.c1;
        next_st.wr_last = st.c2.wr_n;
        next_st.ce_last = st.c2.ce_n;
        next_st.sync1 = CARRIER_SYNC;
        next_st.sync2 = st.sync1;
        next_st.sync_last = st.sync2;
        // Write commits on the rising edge of the write strobe
        commit = !st.wr_last && st.c2.wr_n && !st.ce_last;
        if (commit) begin
            case (st.c2.addr)
                ADDR_LEAP_HI: next_st.leap_hi = st.c2.data;
                ADDR_LEAP_LO: next_st.leap_lo = st.c2.data;
                ADDR_PHASE: next_st.phase_off = st.c2.data;
                ADDR_FREQ_HI: next_st.freq_hi = st.c2.data;
                ADDR_FREQ_LO: next_st.freq_lo = st.c2.data;
                ADDR_MAIN: next_st.main_ctl = st.c2.data;
                ADDR_FIR: next_st.fir_ctl = st.c2.data;
                ADDR_DEV: next_st.dev_ctl = st.c2.data;
                default: ;
            endcase
        end
        // Offset write or sync pin edge restarts the carrier phase
        next_st.preset = (commit && st.c2.addr == ADDR_PHASE)
            || (st.sync2 && !st.sync_last);

        next_st.rd_oe = !st.c2.rd_n && !st.c2.ce_n;
        case (st.c2.addr)
            ADDR_LEAP_HI: next_st.rd_data = st.leap_hi;
            ADDR_LEAP_LO: next_st.rd_data = st.leap_lo;
            ADDR_PHASE: next_st.rd_data = st.phase_off;
            ADDR_FREQ_HI: next_st.rd_data = st.freq_hi;
            ADDR_FREQ_LO: next_st.rd_data = st.freq_lo;
            ADDR_MAIN: next_st.rd_data = st.main_ctl;
            ADDR_FIR: next_st.rd_data = st.fir_ctl;
            ADDR_DEV: next_st.rd_data = st.dev_ctl;
            default: next_st.rd_data = 16'h0000;
        endcase

        // Half-band: zeroed line while bypassed saves toggling
        hb_en = st.fir_ctl[HB_EN_BIT];
        nline0 = hb_en ? SHAPED_IQ : '0;
        next_st.hb_line = hb_en ? st.hb_line : '0;
        if (SHAPED_VALID) begin
            next_st.hb_prev = st.hb_cur;
            if (hb_en) begin
                next_st.hb_line = {st.hb_line[4:0], nline0};
                // Midpoint phase first, then the centre-tap sample
                next_st.hb_cur.re = hb_a(nline0.re, st.hb_line[0].re,
                    st.hb_line[1].re, st.hb_line[2].re, st.hb_line[3].re,
                    st.hb_line[4].re);
                next_st.hb_cur.im = hb_a(nline0.im, st.hb_line[0].im,
                    st.hb_line[1].im, st.hb_line[2].im, st.hb_line[3].im,
                    st.hb_line[4].im);
                next_st.hb_pend = 1'b1;
            end else begin
                next_st.hb_cur = SHAPED_IQ;
                next_st.hb_pend = 1'b0;
            end
        end else if (st.hb_pend) begin
            next_st.hb_prev = st.hb_cur;
            next_st.hb_cur = st.hb_line[2];
            next_st.hb_pend = 1'b0;
        end

        next_st.interp.re = lerp(st.hb_prev.re, st.hb_cur.re, FINE_PHASE);
        next_st.interp.im = lerp(st.hb_prev.im, st.hb_cur.im, FINE_PHASE);

        if (nco_zero) begin
            next_st.mix = st.interp;
        end else begin
            next_st.mix.re = mixp(st.interp.re, nco_cos, st.interp.im, nco_sin,
                1'b1);
            next_st.mix.im = mixp(st.interp.im, nco_cos, st.interp.re, nco_sin,
                1'b0);
        end

        next_st.sum.re = sat21(48'(st.mix.re) + 48'(OTHER_CHANNELS[0].re)
            + 48'(OTHER_CHANNELS[1].re) + 48'(OTHER_CHANNELS[2].re));
        next_st.sum.im = sat21(48'(st.mix.im) + 48'(OTHER_CHANNELS[0].im)
            + 48'(OTHER_CHANNELS[1].im) + 48'(OTHER_CHANNELS[2].im));
        next_st.sum_d = {st.sum_d[2:0], st.sum};
        dly = st.sum_d[chain_pos];

        next_st.p1 = {CASC_REAL_IN, CASC_IMAG_IN};
        next_st.p2 = st.p1;
        // Bus carries the top 20 of the 21 bits
        if (st.dev_ctl[DEV_CASC_EN_BIT] && mode == M_CASCADE) begin
            next_st.casc_in.re = {st.p2.re, 1'b0};
            next_st.casc_in.im = {st.p2.im, 1'b0};
        end else begin
            next_st.casc_in = '0;
        end
        next_st.chain.re = sat21(48'(dly.re) + 48'(st.casc_in.re));
        next_st.chain.im = sat21(48'(dly.im) + 48'(st.casc_in.im));

        src = (mode == M_CASCADE) ? st.chain : st.sum;
        re20 = src.re[20:1];
        im20 = src.im[20:1];
        next_st.mux_phase = (mode == M_MUXED) ? !st.mux_phase : 1'b0;
        if (!st.mux_phase) begin
            next_st.mux_hold = src.im;
        end
        mx = st.mux_phase ? st.mux_hold[20:1] : re20;
        next_st.strobe = mode == M_MUXED && !st.mux_phase
            && st.dev_ctl[DEV_STRB_EN_BIT];
        next_st.oe = (mode != M_CASCADE);
        case (mode)
            M_CASCADE: next_st.bus_hi = {im20, re20, 20'h00000, 20'h00000};
            M_REAL: next_st.bus_hi = {4{re20}};
            M_IMAG: next_st.bus_hi = {4{im20}};
            M_MUXED: next_st.bus_hi = {4{mx}};
            M_MUXED_2X: next_st.bus_hi = {4{re20}};
            M_CPLX1: next_st.bus_hi = {re20, re20, im20, re20};
            M_CPLX2: next_st.bus_hi = {im20, re20, re20, re20};
            M_CPLX3: next_st.bus_hi = {im20, re20, im20, re20};
            default: next_st.bus_hi = '0;
        endcase
        next_st.bus_lo = (mode == M_MUXED_2X) ? {4{im20}} : next_st.bus_hi;
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            st <= '0;
            st.c1 <= '1;
            st.c2 <= '1;
            st.wr_last <= 1'b1;
            st.ce_last <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Clock-phase select only differs in double-rate mode; hold time is thin
    assign CASC_REAL_OUT = REF_CLK ? st.bus_hi[B_CR] : st.bus_lo[B_CR];
    assign CASC_IMAG_OUT = REF_CLK ? st.bus_hi[B_CI] : st.bus_lo[B_CI];
    assign OUT_REAL_BUS = REF_CLK ? st.bus_hi[B_OR] : st.bus_lo[B_OR];
    assign OUT_IMAG_BUS = REF_CLK ? st.bus_hi[B_OI] : st.bus_lo[B_OI];
    assign CASC_OE = st.oe;
    assign REAL_SAMPLE_STROBE = st.strobe;
    assign CPU_DATA_OUT = st.rd_data;
    assign CPU_DATA_OE = st.rd_oe;
    assign LEAP_COUNT_VALUE = {st.leap_hi, st.leap_lo};

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    chk_leap_upper: assert property (!st.wr_last && st.c2.wr_n && !st.ce_last
        && st.c2.addr == ADDR_LEAP_HI |=>
        LEAP_COUNT_VALUE[31:16] == $past(st.c2.data))
        else $error("leap upper half not written");
    chk_hb_bypass_zero: assert property (!st.fir_ctl[HB_EN_BIT] ##1
        !st.fir_ctl[HB_EN_BIT] |-> st.hb_line == '0)
        else $error("half-band input not zero while bypassed");
    chk_hb_two_phases: assert property (SHAPED_VALID && st.fir_ctl[HB_EN_BIT]
        ##1 !SHAPED_VALID |-> st.hb_pend ##1 (!st.hb_pend
        && st.hb_cur == $past(st.hb_line[2])))
        else $error("half-band second phase missing");
    chk_zero_pass: assert property (nco_zero |=> st.mix == $past(st.interp))
        else $error("mixer not transparent at zero frequency");
    chk_bus_dir: assert property (mode == M_CASCADE |=> !CASC_OE ##1 1'b1)
        else $error("cascade buses driven in cascade mode");
    chk_casc_gate: assert property (!st.dev_ctl[DEV_CASC_EN_BIT] [*2]
        |-> st.casc_in == '0)
        else $error("cascade input not forced to zero");
    chk_chain_sat: assert property (!st.sum_d[chain_pos].re[20]
        && !st.casc_in.re[20] |=> !st.chain.re[20])
        else $error("chain sum wrapped");
    chk_strobe_alt: assert property (REAL_SAMPLE_STROBE |=> !REAL_SAMPLE_STROBE)
        else $error("real strobe on consecutive clocks");
    chk_route_real: assert property (mode == M_REAL ##1 mode == M_REAL
        |-> st.bus_hi[B_OR] == st.bus_hi[B_CI])
        else $error("real mode buses differ");

    cov_muxed: cover property (REAL_SAMPLE_STROBE ##1 !REAL_SAMPLE_STROBE);
    cov_hb: cover property (SHAPED_VALID && st.fir_ctl[HB_EN_BIT]);
    cov_cascade: cover property (mode == M_CASCADE && st.casc_in != '0);
    cov_double_rate: cover property (mode == M_MUXED_2X);
    cov_preset: cover property (st.preset);
endmodule : upconverter_channel_backend
`default_nettype wire

// ### tb/cascade_source.sv
// Previous cascade stage sharing the two bidirectional buses
`timescale 1ns/1ps
`default_nettype none
module cascade_source (
    input wire logic dut_oe,
    input wire logic [19:0] want_re,
    input wire logic [19:0] want_im,
    input wire logic [19:0] dut_re,
    input wire logic [19:0] dut_im,
    output logic [19:0] wire_re,
    output logic [19:0] wire_im
);
    // Drives only while the device listens, so the wire never floats
    assign wire_re = dut_oe ? dut_re : want_re;
    assign wire_im = dut_oe ? dut_im : want_im;
endmodule : cascade_source
`default_nettype wire

// ### tb/upconverter_channel_backend_test.sv
// Register, routing and cascade tests of the channel back end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module upconverter_channel_backend_test;
    import upc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
    logic [6:0] addr = 7'h00;
    logic [15:0] din = 16'h0000, rdata, dout;
    logic oe, casc_oe, strb, vld = 1'b0;
    cplx_t iq = '{re: 21'h0c0000, im: 21'h1f0000};
    logic [19:0] want_re = 20'h00000, want_im = 20'h00000;
    logic [19:0] c_re, c_im, w_re, w_im, o_re, o_im;
    logic [31:0] leap;
    int n_fail = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    upconverter_channel_backend dut (.REF_CLK(clk), .RESET(rst),
        .CPU_CE_N(ce_n), .CPU_WR_N(wr_n), .CPU_RD_N(rd_n), .CPU_ADDR(addr),
        .CPU_DATA_IN(din), .CPU_DATA_OUT(dout), .CPU_DATA_OE(oe),
        .SHAPED_IQ(iq), .SHAPED_VALID(vld), .FINE_PHASE(8'h00),
        .OTHER_CHANNELS('0), .CARRIER_SYNC(1'b0), .CASC_REAL_IN(w_re),
        .CASC_IMAG_IN(w_im), .CASC_REAL_OUT(c_re), .CASC_IMAG_OUT(c_im),
        .CASC_OE(casc_oe), .OUT_REAL_BUS(o_re), .OUT_IMAG_BUS(o_im),
        .REAL_SAMPLE_STROBE(strb), .LEAP_COUNT_VALUE(leap));
    cascade_source partner (.dut_oe(casc_oe), .want_re(want_re),
        .want_im(want_im), .dut_re(c_re), .dut_im(c_im), .wire_re(w_re),
        .wire_im(w_im));
    // Shaped samples every second cycle, the densest spacing allowed
    always @(negedge clk) vld <= rst ? 1'b0 : ~vld;
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n
    // Data held well past the commit, which trails the strobe by 3 clocks
    task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        ce_n = 1'b0;
        addr = a;
        din = d;
        wr_n = 1'b0;
        wait_n(2);
        wr_n = 1'b1;
        wait_n(5);
        ce_n = 1'b1;
        wait_n(1);
    endtask : reg_write
    task automatic reg_read(input logic [6:0] a, output logic [15:0] d);
        @(negedge clk);
        ce_n = 1'b0;
        rd_n = 1'b0;
        addr = a;
        wait_n(5);
        d = dout;
        `CHK(oe, 1'b1)
        ce_n = 1'b1;
        rd_n = 1'b1;
        wait_n(4);
    endtask : reg_read
    task automatic results;
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    initial begin
        #(25ns * 20000);
        n_fail++;
        results();
    end
    initial begin
        wait_n(16);
        rst = 1'b0;
        `CHK(casc_oe, 1'b0)
        reg_write(ADDR_LEAP_HI, 16'h0b9f);
        reg_write(ADDR_LEAP_LO, 16'h76c0);
        `CHK(leap, 32'h0b9f76c0)
        reg_read(ADDR_LEAP_HI, rdata);
        `CHK(rdata, 16'h0b9f)
        reg_read(7'h7f, rdata);
        `CHK(rdata, 16'h0000)
        // Zero carrier, half-band bypassed: shaped data reaches the buses
        reg_write(ADDR_DEV, 16'h0100);
        wait_n(20);
        `CHK(casc_oe, 1'b1)
        `CHK({o_re, o_im, w_re, w_im}, {4{20'h60000}})
        reg_write(ADDR_DEV, 16'h0200);
        wait_n(20);
        `CHK({o_re, o_im, w_re, w_im}, {4{20'hf8000}})
        // Complex and double-rate modes need the main control mode bit
        reg_write(ADDR_MAIN, 16'h0080);
        reg_write(ADDR_DEV, 16'h0100);
        wait_n(20);
        `CHK({c_re, c_im, o_re, o_im}, {20'h60000, 20'hf8000, 20'h60000,
            20'h60000})
        reg_write(ADDR_DEV, 16'h0200);
        wait_n(20);
        `CHK({c_re, c_im, o_re, o_im}, {20'h60000, 20'h60000, 20'h60000,
            20'hf8000})
        reg_write(ADDR_DEV, 16'h0300);
        wait_n(20);
        `CHK({c_re, c_im, o_re, o_im}, {20'h60000, 20'hf8000, 20'h60000,
            20'hf8000})
        // Double rate: imaginary while the clock is low, real while high
        reg_write(ADDR_DEV, 16'h0000);
        wait_n(20);
        `CHK(o_re, 20'hf8000)
        @(posedge clk);
        #1;
        `CHK(o_re, 20'h60000)
        reg_write(ADDR_MAIN, 16'h0000);
        // Muxed: strobe marks real words, imaginary follows
        reg_write(ADDR_DEV, 16'h0320);
        wait_n(20);
        repeat (4) begin
            `CHK(o_re, strb ? 20'h60000 : 20'hf8000)
            wait_n(1);
        end
        // Half-band on: unit DC gain keeps a steady input unchanged
        reg_write(ADDR_DEV, 16'h0100);
        reg_write(ADDR_FIR, 16'h0200);
        wait_n(30);
        `CHK({o_re, o_im}, {20'h60000, 20'h60000})
        // Quarter-turn offset, tiny positive step: re becomes -Q
        reg_write(ADDR_PHASE, 16'h4000);
        reg_write(ADDR_FREQ_LO, 16'h0001);
        wait_n(20);
        `CHK(o_re, 20'h07fff)
        reg_write(ADDR_FREQ_LO, 16'h0000);
        // Cascade: both parts overflow and must clamp, not wrap
        want_re = 20'h40000;
        want_im = 20'h80000;
        reg_write(ADDR_DEV, 16'h0008);
        wait_n(20);
        `CHK(casc_oe, 1'b0)
        `CHK({o_re, o_im}, {20'h7ffff, 20'h80000})
        reg_write(ADDR_DEV, 16'h0000);
        wait_n(20);
        `CHK({o_re, o_im}, {20'h60000, 20'hf8000})
        results();
    end
endmodule : upconverter_channel_backend_test
`default_nettype wire
